// >>> nvp_defines.vh
`ifndef NVP_DEFINES_VH
`define NVP_DEFINES_VH

// ==========================================
// Register offsets
`define NVP_A_LATCH0    8'h00
`define NVP_A_LATCH1    8'h01
`define NVP_A_LATCH2    8'h02
`define NVP_A_LATCH3    8'h03
`define NVP_A_STATUS    8'h04
`define NVP_A_CLEAR     8'h05
`define NVP_A_EE_ROW    8'h06
`define NVP_A_EE_DATA   8'h07
`define NVP_A_EE_CMD    8'h08
`define NVP_A_PROT_ROW  8'h09
`define NVP_A_PROT_LVL  8'h0A
`define NVP_A_CTRL      8'h0B
`define NVP_A_EE_IDX    8'h0C

// ==========================================
// Boot latch factory defaults
`define NVP_LATCH0_RST  8'h00
`define NVP_LATCH1_RST  8'h00
`define NVP_LATCH2_RST  8'h00
`define NVP_LATCH3_RST  8'h02

// ==========================================
// Boot latch fields
`define NVP_F_EXTERNAL_RESET_INPUT      7
`define NVP_F_PHS_HI    7
`define NVP_F_PHS_LO    4
`define NVP_F_ECC       3
`define NVP_F_DPS_HI    2
`define NVP_F_DPS_LO    1
`define NVP_F_SPEED     0

// ==========================================
// Protection levels and debug port codes
`define NVP_LVL_UNPROT  2'b00
`define NVP_LVL_FACTORY 2'b01
`define NVP_LVL_FIELD   2'b10
`define NVP_LVL_FULL    2'b11
`define NVP_DPS_JTAG5   2'b00
`define NVP_DPS_JTAG4   2'b01
`define NVP_DPS_SWD     2'b10
`define NVP_DPS_OFF     2'b11

// ==========================================
// Status, command and control bits
`define NVP_S_BUSY      0
`define NVP_S_PROT_ERR  1
`define NVP_S_EE_ERR    2
`define NVP_S_SBE       3
`define NVP_S_DBE       4
`define NVP_S_SECURE    5
`define NVP_S_OPEN      6
`define NVP_C_WRITE     0
`define NVP_C_ERASE     1
`define NVP_K_CHIP_ERASE 0
`define NVP_K_SECURE    1

// ==========================================
// Sizes and timing
`define NVP_FL_ROWS     256
`define NVP_EE_ROWS     128
`define NVP_EE_ROW_B    16
`define NVP_CLK_NS      10
`define NVP_EE_WR_NS    20000

`endif

// >>> nvp_secded.v
`default_nettype none

// ==========================================
// SECDED over one 8-byte group
module nvp_secded (
  // Group data and stored check byte
  input  wire [63:0] data,
  input  wire [7:0]  check_in,
  // Results
  output reg  [7:0]  check_gen,
  output reg  [63:0] data_fix,
  output reg         single_err,
  output reg         double_err
);

  integer i;
  reg [6:0] gen;
  reg [6:0] syn;
  reg       odd;

  // Hamming position of data bit k, skipping powers of two
  function [6:0] nvp_pos;
    input integer k;
    integer p;
    integer j;
    begin
      nvp_pos = 7'h00;
      j = 0;
      for (p = 3; p < 72; p = p + 1) begin
        if ((p & (p - 1)) != 0) begin
          if (j == k)
            nvp_pos = p[6:0];
          j = j + 1;
        end
      end
    end
  endfunction

  always @* begin
    gen = 7'h00;
    for (i = 0; i < 64; i = i + 1) begin
      if (data[i])
        gen = gen ^ nvp_pos(i);
    end
    syn = gen ^ check_in[6:0];
    check_gen = {(^data) ^ (^gen), gen};
    odd = (^data) ^ (^check_in);
    // Odd overall parity means one flipped bit, even with a syndrome two
    single_err = odd;                           // see [RL22]
    double_err = ~odd & (syn != 7'h00);         // see [RL22]
    data_fix = data;
    for (i = 0; i < 64; i = i + 1) begin
      if (odd && (nvp_pos(i) == syn))
        data_fix[i] = ~data[i];
    end
  end

endmodule

`default_nettype wire

// >>> nvp_top.v
// Summary of operation
// [RL1] Flash block: 256 data plus 32 ECC bytes
// [RL2] Up to 256 blocks in 64 KB
// [RL3] One of four levels per flash row
// [RL4] Level changes only after complete flash erase; reset also sets every row to unprotected
// [RL5] Level decides external/internal read/write access
// [RL6] Bootloader users pick field upgrade level
// [RL7] Device security disables test and debug ports
// [RL8] EEPROM reads are direct random byte accesses
// [RL9] EEPROM written only through programming commands
// [RL10] Flash access continues during EEPROM write
// [RL11] EEPROM erase/write per 16-byte row, 128 rows
// [RL12] No instruction fetch from EEPROM
// [RL13] Firmware handles any EEPROM error correction
// [RL14] Four latch bytes applied at reset
// [RL15] Two-bit port reset drive mode fields
// [RL16] Latch bit selects GPIO or external reset
// [RL17] Latch bit selects 12 or 48 MHz boot
// [RL18] Two-bit field selects debug port
// [RL19] Latch bit enables ECC use of bytes
// [RL20] Four-bit digital clock phase delay field
// [RL21] Configuring party limits latch rewrites
// [RL22] ECC corrects single, detects double per group
// [RL23] Refused access changes nothing, returns no data
`default_nettype none
`include "nvp_defines.vh"

module nvp_top #(
  parameter integer EE_WR_NS = `NVP_EE_WR_NS
) (
  // Clock and reset
  input  wire         clk,
  input  wire         reset,
  // Register port
  input  wire [7:0]   reg_addr,
  input  wire [7:0]   reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output reg  [7:0]   reg_rdata,
  // Flash requests
  input  wire         fl_req,
  input  wire         fl_ext,
  input  wire         fl_wr,
  input  wire [12:0]  fl_addr,
  input  wire [63:0]  fl_wdata,
  output reg          fl_rvalid,
  output reg  [63:0]  fl_rdata,
  output reg          fl_denied,
  // Flash array
  output wire         fa_en,
  output wire         fa_we,
  output wire [12:0]  fa_addr,
  output wire [63:0]  fa_wdata,
  output wire [7:0]   fa_wcheck,
  input  wire [63:0]  fa_rdata,
  input  wire [7:0]   fa_rcheck,
  // EEPROM requests
  input  wire         ee_req,
  input  wire         ee_wr,
  input  wire         ee_fetch,
  input  wire [10:0]  ee_addr,
  output reg          ee_rvalid,
  output reg  [7:0]   ee_rdata,
  output reg          ee_denied,
  // EEPROM array
  output wire         ea_en,
  output wire [10:0]  ea_addr,
  input  wire [7:0]   ea_rdata,
  output reg          ea_prog,
  output reg          ea_erase,
  output reg  [6:0]   ea_row,
  output reg  [127:0] ea_wdata,
  // Security fuse
  input  wire         secure_fuse,
  output reg          secure_burn,
  // Boot configuration
  output wire [17:0]  port_reset_drive_mode,
  output wire         ext_reset_pin_select,
  output wire         boot_clock_speed,
  output wire [1:0]   debug_port_select,
  output wire         jtag5_en,
  output wire         jtag4_en,
  output wire         swd_en,
  output wire         test_port_en,
  output wire         ecc_space_enable,
  output wire [3:0]   digital_clock_phase_delay,
  output wire         dev_secure
);

  // ==========================================
  // Constants
  localparam integer EE_WR_CYC_I = EE_WR_NS / `NVP_CLK_NS;
  localparam [11:0]  EE_WR_CYC   = EE_WR_CYC_I[11:0];
  localparam [1:0]   OP_IDLE     = 2'b00;
  localparam [1:0]   OP_WRITE    = 2'b01;
  localparam [1:0]   OP_ERASE    = 2'b10;

  // ==========================================
  // Access check per protection level
  function nvp_allow;
    input [1:0] lvl;
    input       ext;
    input       wr;
    begin
      case (lvl)
        `NVP_LVL_UNPROT:  nvp_allow = 1'b1;
        `NVP_LVL_FACTORY: nvp_allow = ~(ext & ~wr);
        `NVP_LVL_FIELD:   nvp_allow = ~ext;
        `NVP_LVL_FULL:    nvp_allow = ~ext & ~wr;
        default:          nvp_allow = 1'b0;
      endcase
    end
  endfunction

  // ==========================================
  // State
  integer     k;
  reg [7:0]   nv_q [0:3];
  reg [7:0]   act_q [0:3];
  reg         apply_q;
  reg [1:0]   prot_q [0:`NVP_FL_ROWS-1];
  reg [7:0]   prot_row_q;
  reg         open_q;
  reg         sec_q;
  reg         prot_err_q;
  reg         ee_err_q;
  reg         sbe_q;
  reg         dbe_q;
  reg [7:0]   ee_buf_q [0:`NVP_EE_ROW_B-1];
  reg [3:0]   ee_idx_q;
  reg [6:0]   ee_row_q;
  reg [1:0]   op_q;
  reg [11:0]  cnt_q;
  reg         f1_rd_q;
  reg         f1_den_q;
  reg         e1_rd_q;
  reg         e1_den_q;
  reg [7:0]   rd_d;

  wire        wr_hit  = reg_wr;
  wire        busy    = (op_q != OP_IDLE);
  wire [7:0]  fl_row  = fl_addr[12:5];
  wire [1:0]  fl_lvl  = prot_q[fl_row];
  wire        ext_ok  = ~(fl_ext & sec_q);
  wire        fl_ok   = nvp_allow(fl_lvl, fl_ext, fl_wr) & ext_ok;
  wire        ee_ok   = ee_req & ~ee_wr & ~ee_fetch;
  wire        ee_bad  = ee_req & (ee_wr | ee_fetch);
  wire        ecc_on  = act_q[3][`NVP_F_ECC];
  wire        fl_bad  = fl_req & ~fl_ok;
  wire        cmd_go  = wr_hit & (reg_addr == `NVP_A_EE_CMD);
  wire        cmd_bad = cmd_go & busy;
  wire        lvl_go  = wr_hit & (reg_addr == `NVP_A_PROT_LVL);
  wire        erase_go = wr_hit & (reg_addr == `NVP_A_CTRL) & reg_wdata[`NVP_K_CHIP_ERASE];
  wire        clr_go  = wr_hit & (reg_addr == `NVP_A_CLEAR);
  wire [63:0] fix_data;
  wire [7:0]  gen_check;
  wire        rd_sbe;
  wire        rd_dbe;

  // ==========================================
  // ECC on read data and write data
  nvp_secded u_rd_ecc (
    .data       (fa_rdata),
    .check_in   (fa_rcheck),
    .check_gen  (),
    .data_fix   (fix_data),
    .single_err (rd_sbe),
    .double_err (rd_dbe)
  );

  nvp_secded u_wr_ecc (
    .data       (fl_wdata),
    .check_in   (8'h00),
    .check_gen  (gen_check),
    .data_fix   (),
    .single_err (),
    .double_err ()
  );

  // ==========================================
  // Flash array path
  // 8192 words of 8 bytes, 32 words per 256-byte row
  assign fa_en     = fl_req & fl_ok;            // see [RL23]
  assign fa_we     = fl_req & fl_ok & fl_wr;    // see [RL5]
  assign fa_addr   = fl_addr;                   // see [RL2]
  assign fa_wdata  = fl_wdata;
  // Extra byte carries ECC only when enabled; else written as 8'h00
  assign fa_wcheck = ecc_on ? gen_check : 8'h00; // see [RL1]

  always @(posedge clk) begin
    if (reset) begin
      f1_rd_q   <= 1'b0;
      f1_den_q  <= 1'b0;
      fl_rvalid <= 1'b0;
      fl_denied <= 1'b0;
      fl_rdata  <= 64'h0000_0000_0000_0000;
    end else begin
      f1_rd_q   <= fl_req & ~fl_wr & fl_ok;
      f1_den_q  <= fl_bad;
      fl_rvalid <= f1_rd_q;
      fl_denied <= f1_den_q;
      if (f1_rd_q)
        fl_rdata <= ecc_on ? fix_data : fa_rdata; // see [RL22]
      else
        fl_rdata <= 64'h0000_0000_0000_0000;      // see [RL23]
    end
  end

  // ==========================================
  // Protection levels
  // Window opens on chip erase and closes on the first flash access
  always @(posedge clk) begin
    if (reset) begin
      for (k = 0; k < `NVP_FL_ROWS; k = k + 1)
        prot_q[k] <= `NVP_LVL_UNPROT;
      prot_row_q <= 8'h00;
      open_q     <= 1'b0;
    end else begin
      if (wr_hit && reg_addr == `NVP_A_PROT_ROW)
        prot_row_q <= reg_wdata;
      if (erase_go) begin
        for (k = 0; k < `NVP_FL_ROWS; k = k + 1)
          prot_q[k] <= `NVP_LVL_UNPROT;         // see [RL4]
        open_q <= 1'b1;
      end else begin
        if (lvl_go && open_q)
          prot_q[prot_row_q] <= reg_wdata[1:0]; // see [RL3]
        if (fl_req)
          open_q <= 1'b0;                       // see [RL4]
      end
    end
  end

  // ==========================================
  // Sticky status, set wins over clear
  always @(posedge clk) begin
    if (reset) begin
      prot_err_q <= 1'b0;
      ee_err_q   <= 1'b0;
      sbe_q      <= 1'b0;
      dbe_q      <= 1'b0;
    end else begin
      prot_err_q <= (fl_bad | (lvl_go & ~open_q)) |
                    (prot_err_q & ~(clr_go & reg_wdata[`NVP_S_PROT_ERR]));
      ee_err_q   <= (ee_bad | cmd_bad) |
                    (ee_err_q & ~(clr_go & reg_wdata[`NVP_S_EE_ERR]));
      sbe_q      <= (f1_rd_q & ecc_on & rd_sbe) |
                    (sbe_q & ~(clr_go & reg_wdata[`NVP_S_SBE]));
      dbe_q      <= (f1_rd_q & ecc_on & rd_dbe) |
                    (dbe_q & ~(clr_go & reg_wdata[`NVP_S_DBE]));
    end
  end

  // ==========================================
  // Device security
  // Fuse is read after release; nothing but reset clears it
  always @(posedge clk) begin
    if (reset) begin
      sec_q       <= 1'b0;
      secure_burn <= 1'b0;
    end else begin
      secure_burn <= wr_hit & (reg_addr == `NVP_A_CTRL) &
                     reg_wdata[`NVP_K_SECURE] & ~sec_q;
      if ((apply_q & secure_fuse) | secure_burn)
        sec_q <= 1'b1;                          // see [RL7]
    end
  end

  // ==========================================
  // EEPROM direct reads
  assign ea_en   = ee_ok;                       // see [RL8]
  assign ea_addr = ee_addr;

  always @(posedge clk) begin
    if (reset) begin
      e1_rd_q   <= 1'b0;
      e1_den_q  <= 1'b0;
      ee_rvalid <= 1'b0;
      ee_denied <= 1'b0;
      ee_rdata  <= 8'h00;
    end else begin
      e1_rd_q   <= ee_ok;
      e1_den_q  <= ee_bad;                      // see [RL12]
      ee_rvalid <= e1_rd_q;
      ee_denied <= e1_den_q;                    // see [RL9]
      ee_rdata  <= e1_rd_q ? ea_rdata : 8'h00;
    end
  end

  // ==========================================
  // EEPROM row programming
  // Runs beside the flash path, which never waits on it
  always @* begin
    for (k = 0; k < `NVP_EE_ROW_B; k = k + 1)
      ea_wdata[k*8 +: 8] = ee_buf_q[k];
  end

  always @(posedge clk) begin
    if (reset) begin
      for (k = 0; k < `NVP_EE_ROW_B; k = k + 1)
        ee_buf_q[k] <= 8'h00;
      ee_idx_q <= 4'h0;
      ee_row_q <= 7'h00;
      op_q     <= OP_IDLE;
      cnt_q    <= 12'h000;
      ea_prog  <= 1'b0;
      ea_erase <= 1'b0;
      ea_row   <= 7'h00;
    end else begin
      if (wr_hit && reg_addr == `NVP_A_EE_ROW && !busy) begin
        ee_row_q <= reg_wdata[6:0];             // see [RL11]
        ee_idx_q <= 4'h0;
      end
      if (wr_hit && reg_addr == `NVP_A_EE_DATA && !busy) begin
        ee_buf_q[ee_idx_q] <= reg_wdata;        // see [RL9]
        ee_idx_q <= ee_idx_q + 4'h1;
      end
      case (op_q)
        OP_IDLE: begin
          if (cmd_go && reg_wdata[`NVP_C_WRITE]) begin
            op_q    <= OP_WRITE;
            ea_prog <= 1'b1;                    // see [RL11]
            ea_row  <= ee_row_q;
            cnt_q   <= EE_WR_CYC - 12'h001;
          end else if (cmd_go && reg_wdata[`NVP_C_ERASE]) begin
            op_q     <= OP_ERASE;
            ea_erase <= 1'b1;                   // see [RL11]
            ea_row   <= ee_row_q;
            cnt_q    <= EE_WR_CYC - 12'h001;
          end
        end
        OP_WRITE, OP_ERASE: begin
          if (cnt_q == 12'h000) begin
            op_q     <= OP_IDLE;
            ea_prog  <= 1'b0;
            ea_erase <= 1'b0;
            ee_idx_q <= 4'h0;
          end else begin
            cnt_q <= cnt_q - 12'h001;           // see [RL10]
          end
        end
        default: begin
          op_q     <= OP_IDLE;
          ea_prog  <= 1'b0;
          ea_erase <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Boot configuration latches
  // Stored bytes only take effect at the next reset
  always @(posedge clk) begin
    if (reset) begin
      apply_q  <= 1'b1;
      act_q[0] <= `NVP_LATCH0_RST;
      act_q[1] <= `NVP_LATCH1_RST;
      act_q[2] <= `NVP_LATCH2_RST;
      act_q[3] <= `NVP_LATCH3_RST;
    end else begin
      apply_q <= 1'b0;
      if (apply_q) begin
        for (k = 0; k < 4; k = k + 1)
          act_q[k] <= nv_q[k];                  // see [RL14]
      end
    end
  end

  // Nonvolatile copy: reset leaves it alone except at power-up init
  initial begin
    nv_q[0] = `NVP_LATCH0_RST;
    nv_q[1] = `NVP_LATCH1_RST;
    nv_q[2] = `NVP_LATCH2_RST;
    nv_q[3] = `NVP_LATCH3_RST;
  end

  always @(posedge clk) begin
    if (wr_hit && reg_addr[7:2] == 6'h00 && !sec_q)
      nv_q[reg_addr[1:0]] <= reg_wdata;
  end

  assign port_reset_drive_mode     = {act_q[2][1:0], act_q[1], act_q[0]}; // see [RL15]
  assign ext_reset_pin_select      = act_q[2][`NVP_F_EXTERNAL_RESET_INPUT];  // see [RL16]
  assign boot_clock_speed          = act_q[3][`NVP_F_SPEED]; // see [RL17]
  assign debug_port_select         = act_q[3][`NVP_F_DPS_HI:`NVP_F_DPS_LO];
  assign jtag5_en = ~sec_q & (debug_port_select == `NVP_DPS_JTAG5); // see [RL18]
  assign jtag4_en = ~sec_q & (debug_port_select == `NVP_DPS_JTAG4); // see [RL18]
  assign swd_en   = ~sec_q & (debug_port_select == `NVP_DPS_SWD);   // see [RL7]
  assign test_port_en              = ~sec_q;                 // see [RL7]
  assign ecc_space_enable          = ecc_on;                 // see [RL19]
  assign digital_clock_phase_delay = act_q[3][`NVP_F_PHS_HI:`NVP_F_PHS_LO]; // see [RL20]
  assign dev_secure                = sec_q;

  // ==========================================
  // Register read
  always @* begin
    case (reg_addr)
      `NVP_A_LATCH0:   rd_d = nv_q[0];
      `NVP_A_LATCH1:   rd_d = nv_q[1];
      `NVP_A_LATCH2:   rd_d = nv_q[2];
      `NVP_A_LATCH3:   rd_d = nv_q[3];
      `NVP_A_STATUS:   rd_d = {1'b0, open_q, sec_q, dbe_q, sbe_q,
                               ee_err_q, prot_err_q, busy};
      `NVP_A_EE_ROW:   rd_d = {1'b0, ee_row_q};
      `NVP_A_PROT_ROW: rd_d = prot_row_q;
      `NVP_A_PROT_LVL: rd_d = {6'h00, prot_q[prot_row_q]};
      `NVP_A_EE_IDX:   rd_d = {4'h0, ee_idx_q};
      default:         rd_d = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (reset)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_d : 8'h00;
  end

endmodule

`default_nettype wire

// >>> nvp_checker.sv
`default_nettype none
`include "nvp_defines.vh"
// ==========================================
// Port-level checks
module nvp_checker #(
  parameter integer EE_WR_NS = 20000
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // Register and flash side
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       fl_req,
  input wire logic       fl_ext,
  input wire logic       fl_wr,
  input wire logic       fl_rvalid,
  input wire logic [63:0] fl_rdata,
  input wire logic       fl_denied,
  input wire logic       fa_en,
  // EEPROM side
  input wire logic       ee_req,
  input wire logic       ee_wr,
  input wire logic       ee_fetch,
  input wire logic       ee_rvalid,
  input wire logic       ee_denied,
  input wire logic       ea_en,
  input wire logic       ea_prog,
  // Debug and security
  input wire logic [1:0] debug_port_select,
  input wire logic       jtag5_en,
  input wire logic       jtag4_en,
  input wire logic       swd_en,
  input wire logic       test_port_en,
  input wire logic       dev_secure
);
  localparam int PROG_N = EE_WR_NS / `NVP_CLK_NS;
  logic [15:0] prog_cnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  always @(posedge clk) begin
    if (reset || !ea_prog) prog_cnt_q <= 16'h0000;
    else prog_cnt_q <= prog_cnt_q + 16'h0001;
  end
  chk_refused_flash: assert property (fl_req && !fa_en |-> ##2 fl_denied) else $error("no denial");
  chk_ext_secure: assert property (fl_req && fl_ext && dev_secure |-> !fa_en) else $error("secure leak");
  chk_read_answer: assert property (fl_req && fa_en && !fl_wr |-> ##2 fl_rvalid && !fl_denied) else $error("no read");
  chk_rdata_idle: assert property (!fl_rvalid |-> fl_rdata == 64'h0000_0000_0000_0000) else $error("data leak");
  chk_ee_refuse: assert property (ee_req && (ee_wr || ee_fetch) |-> !ea_en ##2 ee_denied && !ee_rvalid) else $error("ee taken");
  chk_ee_read: assert property (ee_req && ea_en |-> ##2 ee_rvalid) else $error("no ee read");
  chk_ports_secure: assert property (dev_secure |-> !(jtag5_en || jtag4_en || swd_en || test_port_en)) else $error("port open");
  chk_debug_decode: assert property (!dev_secure |-> jtag5_en == (debug_port_select == `NVP_DPS_JTAG5) && jtag4_en == (debug_port_select == `NVP_DPS_JTAG4) && swd_en == (debug_port_select == `NVP_DPS_SWD)) else $error("port decode");
  chk_prog_len: assert property ($fell(ea_prog) |-> prog_cnt_q >= PROG_N && prog_cnt_q <= PROG_N + 1) else $error("prog length");
  chk_secure_sticky: assert property (dev_secure |=> dev_secure) else $error("secure lost");
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray rdata");
  cover property (fl_req && fl_ext && !fa_en);
  cover property ($rose(ea_prog));
  cover property (dev_secure && fl_req);
endmodule

bind nvp_top nvp_checker #(.EE_WR_NS(EE_WR_NS)) nvp_checker_inst (.*);
`default_nettype wire

// >>> nvp_mem_model.sv
`default_nettype none
// ==========================================
// Flash, EEPROM array and fuse model
module nvp_mem_model (
  // Clock
  input  wire logic         clk,
  // Flash array
  input  wire logic         fa_en,
  input  wire logic         fa_we,
  input  wire logic [12:0]  fa_addr,
  input  wire logic [63:0]  fa_wdata,
  input  wire logic [7:0]   fa_wcheck,
  output wire logic [63:0]  fa_rdata,
  output wire logic [7:0]   fa_rcheck,
  input  wire logic         flip_bit,
  // EEPROM array
  input  wire logic         ea_en,
  input  wire logic [10:0]  ea_addr,
  output wire logic [7:0]   ea_rdata,
  input  wire logic         ea_prog,
  input  wire logic         ea_erase,
  input  wire logic [6:0]   ea_row,
  input  wire logic [127:0] ea_wdata,
  // Fuse
  input  wire logic         secure_burn,
  output var  logic         secure_fuse
);
  logic [71:0] fl_mem [0:8191];
  logic [7:0]  ee_mem [0:2047];
  logic [71:0] fl_q = 72'h0;
  logic [7:0]  ee_q = 8'h00;
  logic        busy_q = 1'b0;
  initial begin
    secure_fuse = 1'b0;
    for (int i = 0; i < 8192; i++) fl_mem[i] = 72'h0;
    for (int i = 0; i < 2048; i++) ee_mem[i] = 8'h00;
  end
  assign {fa_rcheck, fa_rdata} = fl_q;
  assign ea_rdata = ee_q;
  // Idle outputs toggle so stale data never looks valid
  always @(posedge clk) begin
    if (fa_en && fa_we) fl_mem[fa_addr] <= {fa_wcheck, fa_wdata};
    fl_q <= (fa_en && !fa_we) ? fl_mem[fa_addr] ^ {71'h0, flip_bit} : ~fl_q;
    ee_q <= ea_en ? ee_mem[ea_addr] : ~ee_q;
    busy_q <= ea_prog || ea_erase;
    if ((ea_prog || ea_erase) && !busy_q)
      for (int k = 0; k < 16; k++) ee_mem[{ea_row, k[3:0]}] <= ea_prog ? ea_wdata[8*k +: 8] : 8'hFF;
    if (secure_burn) secure_fuse <= 1'b1;
  end
endmodule
`default_nettype wire

// >>> test_nv_protect_and_boot_latches.sv
`default_nettype none
`include "nvp_defines.vh"
module test_nv_protect_and_boot_latches;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, fl_req = 0, fl_ext = 0, fl_wr = 0, flip_bit = 0;
  logic ee_req = 0, ee_wr = 0, ee_fetch = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, ee_rdata, ea_rdata, fa_wcheck, fa_rcheck;
  logic [12:0] fl_addr = 0, fa_addr;
  logic [63:0] fl_wdata = 0, fl_rdata, fa_wdata, fa_rdata;
  logic [10:0] ee_addr = 0, ea_addr;
  logic fl_rvalid, fl_denied, fa_en, fa_we, ee_rvalid, ee_denied, ea_en, ea_prog, ea_erase, secure_fuse, secure_burn;
  logic [6:0] ea_row;
  logic [127:0] ea_wdata;
  logic [17:0] port_reset_drive_mode;
  logic [1:0] debug_port_select;
  logic [3:0] digital_clock_phase_delay;
  logic ext_reset_pin_select, boot_clock_speed, jtag5_en, jtag4_en, swd_en, test_port_en, ecc_space_enable, dev_secure;
  logic [66:0] exp_q [$];
  logic [63:0] fmem [0:3];
  logic [7:0] lat [0:3];
  logic [7:0] eb [0:15];
  integer seed = 49, mismatches = 0, comparisons = 0;
  always #5 clk = ~clk;
  nvp_top #(.EE_WR_NS(100)) nvp_top_inst (.*);
  nvp_mem_model nvp_mem_model_inst (.*);
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic take(input logic [2:0] k, input logic [63:0] got);
    logic [66:0] e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : {3'h7, ~got};
    cmp(64'(e[66:64]), 64'(k), "result kind");
    cmp(got, e[63:0], "result data");
  endtask
  // ==========================================
  // Result monitor
  always @(posedge clk) begin : monitor
    logic rd_seen;
    rd_seen = reg_rd;
    #1;
    if (fl_rvalid === 1'b1) take(0, fl_rdata);
    if (fl_denied === 1'b1) take(1, 64'h0);
    if (ee_rvalid === 1'b1) take(2, 64'(ee_rdata));
    if (ee_denied === 1'b1) take(3, 64'h0);
    if (rd_seen) take(4, 64'(reg_rdata));
  end
  // ==========================================
  // Drivers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back({3'd4, 56'h0, x});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic fl(input logic e, input logic w, input logic [7:0] row, input logic ok);
    logic [63:0] d;
    d = {$random(seed), $random(seed)};
    if (!ok) exp_q.push_back({3'd1, 64'h0});
    else if (w) fmem[row] = d;
    else exp_q.push_back({3'd0, fmem[row]});
    @(posedge clk);
    {fl_req, fl_ext, fl_wr, fl_addr, fl_wdata} <= {1'b1, e, w, row, 5'h00, d};
    @(posedge clk);
    fl_req <= 1'b0;
  endtask
  task automatic ee(input logic w, input logic f, input logic [10:0] a, input logic ok, input logic [7:0] x);
    exp_q.push_back({ok ? 3'd2 : 3'd3, ok ? 64'(x) : 64'h0});
    @(posedge clk);
    {ee_req, ee_wr, ee_fetch, ee_addr} <= {1'b1, w, f, a};
    @(posedge clk);
    ee_req <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic ee_wait();
    repeat (2) @(posedge clk);
    for (int n = 0; n < 50 && (ea_prog || ea_erase) !== 1'b0; n++) @(posedge clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #50000;
    mismatches++;
    summarize();
  end
  // ==========================================
  // Main sequence
  initial begin
    for (int r = 0; r < 4; r++) fmem[r] = 64'h0;
    do_reset();
    cmp(64'({port_reset_drive_mode, ext_reset_pin_select, boot_clock_speed, ecc_space_enable, debug_port_select,
      digital_clock_phase_delay}), 64'({21'h0, `NVP_DPS_JTAG4, 4'h0}), "latch defaults");
    rd(`NVP_A_LATCH3, `NVP_LATCH3_RST);
    rd(8'hFF, 8'h00);
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < 4; b++) lat[b] = $random(seed);
      lat[3][2:1] = i[1:0];
      lat[3][3] = (i == 3);
      for (int b = 0; b < 4; b++) wr(b[7:0], lat[b]);
      do_reset();
      for (int b = 0; b < 4; b++) rd(b[7:0], lat[b]);
      cmp(64'(port_reset_drive_mode), 64'({lat[2][1:0], lat[1], lat[0]}), "drive modes");
      cmp(64'(ext_reset_pin_select), 64'(lat[2][7]), "reset pin");
      cmp(64'(boot_clock_speed), 64'(lat[3][0]), "boot speed");
      cmp(64'({jtag5_en, jtag4_en, swd_en}), 64'({i == 0, i == 1, i == 2}), "debug ports");
      cmp(64'(ecc_space_enable), 64'(lat[3][3]), "ecc enable");
      cmp(64'(digital_clock_phase_delay), 64'(lat[3][7:4]), "phase delay");
    end
    $display("test boot latches done");
    wr(`NVP_A_CTRL, 8'h01);
    for (int r = 0; r < 4; r++) begin
      wr(`NVP_A_PROT_ROW, r[7:0]);
      wr(`NVP_A_PROT_LVL, r[7:0]);
    end
    rd(`NVP_A_STATUS, 8'h40);
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 4; c++)
        fl(c[0], !c[1], r[7:0], r == 0 || (r == 1 && !(c[0] && c[1])) || (r == 2 && !c[0]) || (r == 3 && c == 2));
    wr(`NVP_A_PROT_ROW, 8'h03);
    wr(`NVP_A_PROT_LVL, 8'h00);
    rd(`NVP_A_PROT_LVL, 8'h03);
    flip_bit <= 1'b1;
    fl(0, 0, 0, 1);
    flip_bit <= 1'b0;
    rd(`NVP_A_STATUS, 8'h0A);
    wr(`NVP_A_CLEAR, 8'h1E);
    rd(`NVP_A_STATUS, 8'h00);
    $display("test flash protection done");
    ee(1, 0, 11'h010, 0, 0);
    ee(0, 1, 11'h020, 0, 0);
    wr(`NVP_A_EE_ROW, 8'h05);
    for (int k = 0; k < 16; k++) begin
      eb[k] = $random(seed);
      wr(`NVP_A_EE_DATA, eb[k]);
    end
    rd(`NVP_A_EE_IDX, 8'h00);
    wr(`NVP_A_EE_CMD, 8'h01);
    fl(0, 0, 0, 1);
    ee(0, 0, 11'h061, 1, 8'h00);
    ee_wait();
    for (int k = 0; k < 16; k++) ee(0, 0, {7'h05, k[3:0]}, 1, eb[k]);
    wr(`NVP_A_EE_CMD, 8'h02);
    ee_wait();
    ee(0, 0, 11'h053, 1, 8'hFF);
    $display("test eeprom done");
    wr(`NVP_A_CTRL, 8'h02);
    fl(1, 0, 0, 0);
    fl(0, 0, 0, 1);
    wr(`NVP_A_LATCH0, ~lat[0]);
    rd(`NVP_A_LATCH0, lat[0]);
    rd(`NVP_A_STATUS, 8'h26);
    cmp(64'({jtag5_en, jtag4_en, swd_en, test_port_en}), 64'h0, "ports while secure");
    $display("test device security done");
    repeat (4) @(posedge clk);
    cmp(64'(exp_q.size()), 64'h0, "missing results");
    summarize();
  end
endmodule
`default_nettype wire
